//--- rtl/ext_irq_pkg.sv
// Purpose: shared constants and carriers of the extended interrupt unit,
//          the dual data pointer and timer two.
// Assumes: one core clock; an instruction cycle is four clocks.
// Notes:   special-register addresses are the 8-bit direct addresses.
package ext_irq_pkg;
   // timing
   localparam int unsigned CLK_PERIOD_NS   = 25;
   localparam int unsigned INSTR_CLKS      = 4;   // clocks per instruction cycle
   localparam int unsigned T2_FAST_CLKS    = 4;   // rate bit at 1
   localparam int unsigned T2_SLOW_CLKS    = 12;  // rate bit at 0
   localparam int unsigned T2_BAUD_CLKS    = 2;   // baud generator time base
   // special-register addresses
   localparam logic [7:0] A_DP0_LO   = 8'h82;
   localparam logic [7:0] A_DP0_HI   = 8'h83;
   localparam logic [7:0] A_DP1_LO   = 8'h84;
   localparam logic [7:0] A_DP1_HI   = 8'h85;
   localparam logic [7:0] A_PTR_SEL  = 8'h86;
   localparam logic [7:0] A_TCTRL    = 8'h88;
   localparam logic [7:0] A_CLK_RATE = 8'h8e;
   localparam logic [7:0] A_XFLAGS   = 8'h91;
   localparam logic [7:0] A_IRQ_EN   = 8'ha8;
   localparam logic [7:0] A_IRQ_LVL  = 8'hb8;
   localparam logic [7:0] A_T2_CTRL  = 8'hc8;
   localparam logic [7:0] A_T2_REL_L = 8'hca;
   localparam logic [7:0] A_T2_REL_H = 8'hcb;
   localparam logic [7:0] A_T2_CNT_L = 8'hcc;
   localparam logic [7:0] A_T2_CNT_H = 8'hcd;
   localparam logic [7:0] A_XCTRL    = 8'hd8;
   localparam logic [7:0] A_XEN      = 8'he8;
   localparam logic [7:0] A_XLVL     = 8'hf8;
   // bit positions
   localparam int unsigned B_GLOBAL = 7;   // global mask in enable register
   localparam int unsigned B_IT0 = 0, B_IE0 = 1, B_IT1 = 2, B_IE1 = 3;
   localparam int unsigned B_TF0 = 5, B_TF1 = 7;
   localparam int unsigned B_T2_RATE = 5;
   localparam int unsigned B_TF2 = 7, B_RX_SRC = 5, B_TX_SRC = 4, B_RUN = 2;
   localparam int unsigned B_PF_EN = 5, B_PF_FLAG = 4;
   localparam int unsigned B_XFLAG0 = 4;   // flags of inputs two..five start here
   localparam int unsigned B_SEL = 0;
   // reset values
   localparam logic [7:0] CLK_RATE_RST = 8'h01;
   localparam logic [7:0] SFR_RST      = 8'h00;
   // sources in natural priority order, index 0 wins
   localparam int unsigned SRC_INT0 = 0, SRC_TF0 = 1, SRC_INT1 = 2, SRC_TF1 = 3;
   localparam int unsigned SRC_SER = 4, SRC_TF2 = 5, SRC_X2 = 6, SRC_PF = 10;
   localparam int unsigned NSRC = 11;
   localparam logic [15:0] VEC_BASE = 16'h0003;
   localparam logic [15:0] VEC_STEP = 16'h0008;
   // pin polarity: 1 marks an active-low input (0,1,3,5); bit 6 is power loss
   localparam logic [6:0] PIN_LOW_MASK = 7'h2b;

   typedef struct packed {
      logic [7:0] addr;
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } sfr_req_t;

   typedef struct packed {
      logic        take;
      logic [3:0]  src;
      logic [15:0] vector;
   } irq_call_t;

   typedef struct packed {
      logic run;
      logic rx_src;
      logic tx_src;
      logic rate;
   } t2_cfg_t;

   // service-routine address of a source
   function automatic logic [15:0] vector_of(input logic [3:0] src);
      vector_of = VEC_BASE + VEC_STEP * {12'h000, src};
   endfunction : vector_of
endpackage : ext_irq_pkg

//--- rtl/dual_pointer.sv
// Purpose: two 16-bit data pointers and the select register.
// Assumes: the core writes the selected pointer through the data_pointer port.
// Notes:   incrementing the select register flips bit 0 in one write.
module dual_pointer
   import ext_irq_pkg::*;
(
   input  wire logic               clk_i,
   input  wire logic               rst_n_i,
   input  wire ext_irq_pkg::sfr_req_t req_i,
   input  wire logic               data_pointer_we_i,
   input  wire logic [15:0]        data_pointer_wdata_i,
   output logic [15:0]             dp0_o,
   output logic [15:0]             dp1_o,
   output logic                    sel_o
);
   typedef struct packed {
      logic [15:0] dp0;
      logic [15:0] dp1;
      logic        sel;
   } dp_state_t;

   dp_state_t q, d;

   // special-register writes, then pointer-instruction writes to the chosen one
   always_comb begin
      d = q;
      if (req_i.wr) begin
         unique case (req_i.addr)
            A_DP0_LO:  d.dp0[7:0]  = req_i.wdata;
            A_DP0_HI:  d.dp0[15:8] = req_i.wdata;
            A_DP1_LO:  d.dp1[7:0]  = req_i.wdata;
            A_DP1_HI:  d.dp1[15:8] = req_i.wdata;
            A_PTR_SEL: d.sel       = req_i.wdata[B_SEL];
            default:   d.sel       = q.sel;
         endcase
      end
      if (data_pointer_we_i) begin
         if (q.sel) d.dp1 = data_pointer_wdata_i;
         else       d.dp0 = data_pointer_wdata_i;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) q <= '0;
      else          q <= d;
   end

   assign dp0_o = q.dp0;
   assign dp1_o = q.dp1;
   assign sel_o = q.sel;

   property p_sel_write;
      @(posedge clk_i) disable iff (!rst_n_i)
      (req_i.wr && req_i.addr == A_PTR_SEL) |=> (sel_o == $past(req_i.wdata[B_SEL]));
   endproperty
   a_sel_write: assert property (p_sel_write) else $error("select bit not updated");
endmodule : dual_pointer

//--- rtl/timer_two.sv
// Purpose: timer two, 16-bit auto-reload counter and baud generator.
// Assumes: configuration bits live in the parent's timer-two control register, the rate bit in its clock-rate register.
// Notes:   a software write to a count byte wins over the increment.
module timer_two
   import ext_irq_pkg::*;
(
   input  wire logic                  clk_i,
   input  wire logic                  rst_n_i,
   input  wire ext_irq_pkg::t2_cfg_t  cfg_i,
   input  wire ext_irq_pkg::sfr_req_t req_i,
   output logic [15:0]                count_o,
   output logic [15:0]                reload_o,
   output logic                       ovf_o,
   output logic                       baud_o
);
   typedef struct packed {
      logic [15:0] cnt;
      logic [15:0] rel;
      logic [3:0]  pre;
      logic        ovf;
   } t2_state_t;

   t2_state_t q, d;
   logic      baud_mode;
   logic [3:0] limit;
   logic      inc;

   // either baud source switches the counter to the baud time base of two clocks
   assign baud_mode = cfg_i.rx_src | cfg_i.tx_src;
   assign limit = baud_mode ? 4'(T2_BAUD_CLKS - 1)
                : cfg_i.rate ? 4'(T2_FAST_CLKS - 1) : 4'(T2_SLOW_CLKS - 1);
   assign inc = cfg_i.run && (q.pre >= limit);

   always_comb begin
      d = q;
      d.ovf = 1'b0;
      if (!cfg_i.run)   d.pre = '0;
      else if (inc)     d.pre = '0;
      else              d.pre = q.pre + 4'h1;
      if (inc) begin
         if (q.cnt == 16'hffff) begin
            d.cnt = q.rel;
            d.ovf = 1'b1;
         end else begin
            d.cnt = q.cnt + 16'h0001;
         end
      end
      if (req_i.wr) begin
         unique case (req_i.addr)
            A_T2_REL_L: d.rel[7:0]  = req_i.wdata;
            A_T2_REL_H: d.rel[15:8] = req_i.wdata;
            A_T2_CNT_L: d.cnt[7:0]  = req_i.wdata;
            A_T2_CNT_H: d.cnt[15:8] = req_i.wdata;
            default:    d.rel = d.rel;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) q <= '0;
      else          q <= d;
   end

   assign count_o  = q.cnt;
   assign reload_o = q.rel;
   assign ovf_o    = q.ovf;
   assign baud_o   = q.ovf & baud_mode;

   property p_reload;
      @(posedge clk_i) disable iff (!rst_n_i)
      (inc && q.cnt == 16'hffff && !req_i.wr) |=> (ovf_o && count_o == $past(q.rel));
   endproperty
   a_reload: assert property (p_reload) else $error("overflow did not reload");

   property p_stop;
      @(posedge clk_i) disable iff (!rst_n_i)
      (!cfg_i.run && !req_i.wr) |=> (count_o == $past(count_o));
   endproperty
   a_stop: assert property (p_stop) else $error("stopped timer moved");
endmodule : timer_two

//--- rtl/ext_irq_unit.sv
// Purpose: extended interrupt unit with timer two and dual data pointers.
// Assumes: the core reports each instruction end and whether it was a return
//          from interrupt; it performs the long call when a call is offered.
// Notes:   request detection runs on the instruction-cycle tick.
module ext_irq_unit
   import ext_irq_pkg::*;
(
   input  wire logic                  CLOCK_I,
   input  wire logic                  RST_N_I,
   input  wire ext_irq_pkg::sfr_req_t SFR_REQ_I,
   output logic [7:0]                 SFR_RDATA_O,
   input  wire logic                  INSTR_END_I,
   input  wire logic                  RETURN_FROM_ISR_INSTR_I,
   input  wire logic                  SER_IRQ_I,
   input  wire logic                  TF0_SET_I,
   input  wire logic                  TF1_SET_I,
   input  wire logic                  EXT_IRQ_ZERO_LOW_N_I,
   input  wire logic                  EXT_IRQ_ONE_LOW_N_I,
   input  wire logic                  EXT_IRQ_TWO_HIGH_I,
   input  wire logic                  EXT_IRQ_THREE_LOW_N_I,
   input  wire logic                  EXT_IRQ_FOUR_HIGH_I,
   input  wire logic                  EXT_IRQ_FIVE_LOW_N_I,
   input  wire logic                  POWER_LOSS_I,
   input  wire logic                  DATA_POINTER_WE_I,
   input  wire logic [15:0]           DATA_POINTER_WDATA_I,
   output logic [15:0]                DATA_POINTER_O,
   output ext_irq_pkg::irq_call_t     IRQ_CALL_O,
   output logic                       TIMER_TWO_PULSE_O,
   output logic                       BAUD_RX_TICK_O,
   output logic                       BAUD_TX_TICK_O
);
   typedef struct packed {
      logic [7:0] tctrl;
      logic [7:0] clk_rate;
      logic [7:0] xflags;
      logic [7:0] irq_en;
      logic [7:0] irq_lvl;
      logic [7:0] xctrl;
      logic [7:0] xen;
      logic [7:0] xlvl;
      logic [7:0] t2ctrl;
      logic [6:0] s1;       // first synchroniser stage
      logic [6:0] s2;       // second synchroniser stage
      logic [6:0] prev;     // last instruction-cycle sample, active-high
      logic [1:0] div;      // instruction-cycle divider
      logic [2:0] active;   // in service: 0 low, 1 high, 2 top
      logic       ctl_wr;   // enable or level register written this instruction
      logic       pulse;
      logic [7:0] rdata;
      irq_call_t  call;
   } unit_state_t;

   unit_state_t q, d;
   logic [6:0]      pins;
   logic [6:0]      act;
   logic [6:0]      edge_seen;
   logic            tick;
   logic [NSRC-1:0] pend;
   logic [NSRC-1:0] en;
   logic [NSRC-1:0] hi;
   logic [15:0]     dp0, dp1, t2_cnt, t2_rel;
   logic            dp_sel, t2_ovf, t2_baud, baud_mode;
   logic            hi_found, lo_found, take, pf_ok, ctl_now;
   logic [3:0]      hi_idx, lo_idx, pick;
   t2_cfg_t         t2_cfg;

   // lowest index wins among a mask of requests
   function automatic logic [4:0] first_of(input logic [NSRC-1:0] m);
      logic [4:0] r;
      r = '0;
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (m[i]) r = {1'b1, 4'(i)};
      end
      return r;
   endfunction : first_of

   // select-register read: one live bit, the rest reserved as zero
   function automatic logic [7:0] sel_byte(input logic s);
      sel_byte = {7'h00, s};
   endfunction : sel_byte

   dual_pointer u_ptr (
      .clk_i        (CLOCK_I),
      .rst_n_i      (RST_N_I),
      .req_i        (SFR_REQ_I),
      .data_pointer_we_i    (DATA_POINTER_WE_I),
      .data_pointer_wdata_i (DATA_POINTER_WDATA_I),
      .dp0_o        (dp0),
      .dp1_o        (dp1),
      .sel_o        (dp_sel)
   );

   assign t2_cfg = '{run:    q.t2ctrl[B_RUN],
                     rx_src: q.t2ctrl[B_RX_SRC],
                     tx_src: q.t2ctrl[B_TX_SRC],
                     rate:   q.clk_rate[B_T2_RATE]};

   timer_two u_t2 (
      .clk_i    (CLOCK_I),
      .rst_n_i  (RST_N_I),
      .cfg_i    (t2_cfg),
      .req_i    (SFR_REQ_I),
      .count_o  (t2_cnt),
      .reload_o (t2_rel),
      .ovf_o    (t2_ovf),
      .baud_o   (t2_baud)
   );

   assign baud_mode = t2_cfg.rx_src | t2_cfg.tx_src;
   assign DATA_POINTER_O = dp_sel ? dp1 : dp0;

   // pins gathered in bit order 0..5 plus power loss, then normalised
   assign pins = {POWER_LOSS_I, EXT_IRQ_FIVE_LOW_N_I, EXT_IRQ_FOUR_HIGH_I,
                  EXT_IRQ_THREE_LOW_N_I, EXT_IRQ_TWO_HIGH_I,
                  EXT_IRQ_ONE_LOW_N_I, EXT_IRQ_ZERO_LOW_N_I};
   // only the second stage is read; the first may still be settling
   assign act       = q.s2 ^ PIN_LOW_MASK;
   assign edge_seen = act & ~q.prev;
   assign tick      = (q.div == 2'(INSTR_CLKS - 1));

   // pending flags, enables and levels in natural order
   // the serial flag is a level owned by the port, so it is not cleared here
   assign pend = {q.xctrl[B_PF_FLAG], q.xflags[B_XFLAG0 + 3 -: 4], q.t2ctrl[B_TF2],
                  SER_IRQ_I, q.tctrl[B_TF1], q.tctrl[B_IE1], q.tctrl[B_TF0],
                  q.tctrl[B_IE0]};
   assign pf_ok = q.xctrl[B_PF_EN];
   assign en = {pf_ok, {(NSRC - 1){q.irq_en[B_GLOBAL]}} &
                {q.xen[3:0], q.irq_en[5:0]}};
   assign hi = {1'b0, q.xlvl[3:0], q.irq_lvl[5:0]};

   // a control write on the closing clock of an instruction still counts for it
   assign ctl_now = SFR_REQ_I.wr && (SFR_REQ_I.addr == A_IRQ_EN ||
                                     SFR_REQ_I.addr == A_IRQ_LVL ||
                                     SFR_REQ_I.addr == A_XEN ||
                                     SFR_REQ_I.addr == A_XLVL);

   // arbitration: top level, then high, then low, each by natural order
   always_comb begin
      {hi_found, hi_idx} = first_of(pend & en & hi);
      {lo_found, lo_idx} = first_of(pend & en & ~hi);
      pick = 4'(SRC_PF);
      take = 1'b0;
      if (pend[SRC_PF] && en[SRC_PF] && !q.active[2]) begin
         take = 1'b1;
      end else if (hi_found && q.active[2:1] == 2'b00) begin
         take = 1'b1;
         pick = hi_idx;
      end else if (lo_found && q.active == 3'b000) begin
         take = 1'b1;
         pick = lo_idx;
      end
      // a call waits past a return or a control write, then one more instruction
      // the core adds detection and the long call; this block adds one clock
      take = take && INSTR_END_I && !RETURN_FROM_ISR_INSTR_I && !q.ctl_wr && !ctl_now;
   end

   // register file, flags and in-service tracking
   always_comb begin
      d = q;
      d.s1   = pins;
      d.s2   = q.s1;
      d.div  = q.div + 2'h1;
      d.call = '{take: take, src: pick, vector: vector_of(pick)};
      d.pulse = t2_ovf & ~baud_mode;
      // software writes first, so a same-cycle hardware set wins below
      if (SFR_REQ_I.wr) begin
         unique case (SFR_REQ_I.addr)
            A_TCTRL:    d.tctrl    = SFR_REQ_I.wdata;
            A_CLK_RATE: d.clk_rate = SFR_REQ_I.wdata & 8'h3f;
            A_XFLAGS:   d.xflags   = SFR_REQ_I.wdata & 8'hf0;
            A_IRQ_EN:   d.irq_en   = SFR_REQ_I.wdata;
            A_IRQ_LVL:  d.irq_lvl  = SFR_REQ_I.wdata;
            A_XCTRL:    d.xctrl    = SFR_REQ_I.wdata;
            A_XEN:      d.xen      = SFR_REQ_I.wdata;
            A_XLVL:     d.xlvl     = SFR_REQ_I.wdata;
            A_T2_CTRL:  d.t2ctrl   = SFR_REQ_I.wdata;
            default:    d.xlvl     = d.xlvl;
         endcase
      end
      // a write on the closing clock is blocked through ctl_now, so it must not
      // also hold off the following instruction
      if (INSTR_END_I)  d.ctl_wr = 1'b0;
      else if (ctl_now) d.ctl_wr = 1'b1;
      // vectoring clears edge flags of inputs zero and one and timer zero and one flags
      if (take) begin
         if (pick == 4'(SRC_INT0) && q.tctrl[B_IT0]) d.tctrl[B_IE0] = 1'b0;
         if (pick == 4'(SRC_INT1) && q.tctrl[B_IT1]) d.tctrl[B_IE1] = 1'b0;
         if (pick == 4'(SRC_TF0)) d.tctrl[B_TF0] = 1'b0;
         if (pick == 4'(SRC_TF1)) d.tctrl[B_TF1] = 1'b0;
         if (pick == 4'(SRC_PF)) d.active[2] = 1'b1;
         else if (hi[pick])      d.active[1] = 1'b1;
         else                    d.active[0] = 1'b1;
      end
      if (INSTR_END_I && RETURN_FROM_ISR_INSTR_I) begin
         if (q.active[2])      d.active[2] = 1'b0;
         else if (q.active[1]) d.active[1] = 1'b0;
         else                  d.active[0] = 1'b0;
      end
      // instruction-cycle sampling of the pins
      if (tick) begin
         d.prev = act;
         if (q.tctrl[B_IT0]) begin
            if (edge_seen[0]) d.tctrl[B_IE0] = 1'b1;
         end else begin
            d.tctrl[B_IE0] = act[0];
         end
         if (q.tctrl[B_IT1]) begin
            if (edge_seen[1]) d.tctrl[B_IE1] = 1'b1;
         end else begin
            d.tctrl[B_IE1] = act[1];
         end
         for (int k = 0; k < 4; k++) begin
            if (edge_seen[2 + k]) d.xflags[B_XFLAG0 + k] = 1'b1;
         end
         if (edge_seen[6]) d.xctrl[B_PF_FLAG] = 1'b1;
      end
      if (TF0_SET_I) d.tctrl[B_TF0] = 1'b1;
      if (TF1_SET_I) d.tctrl[B_TF1] = 1'b1;
      if (t2_ovf && !baud_mode) d.t2ctrl[B_TF2] = 1'b1;
      // registered read data, reserved bits zero
      d.rdata = 8'h00;
      if (SFR_REQ_I.rd) begin
         unique case (SFR_REQ_I.addr)
            A_DP0_LO:   d.rdata = dp0[7:0];
            A_DP0_HI:   d.rdata = dp0[15:8];
            A_DP1_LO:   d.rdata = dp1[7:0];
            A_DP1_HI:   d.rdata = dp1[15:8];
            A_PTR_SEL:  d.rdata = sel_byte(dp_sel);
            A_TCTRL:    d.rdata = q.tctrl;
            A_CLK_RATE: d.rdata = q.clk_rate;
            A_XFLAGS:   d.rdata = q.xflags;
            A_IRQ_EN:   d.rdata = q.irq_en;
            A_IRQ_LVL:  d.rdata = q.irq_lvl;
            A_XCTRL:    d.rdata = q.xctrl;
            A_XEN:      d.rdata = q.xen;
            A_XLVL:     d.rdata = q.xlvl;
            A_T2_CTRL:  d.rdata = q.t2ctrl;
            A_T2_REL_L: d.rdata = t2_rel[7:0];
            A_T2_REL_H: d.rdata = t2_rel[15:8];
            A_T2_CNT_L: d.rdata = t2_cnt[7:0];
            A_T2_CNT_H: d.rdata = t2_cnt[15:8];
            default:    d.rdata = 8'h00;
         endcase
      end
   end

   // one register for the whole unit; reset to constants only
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         q          <= '0;
         q.clk_rate <= CLK_RATE_RST;
         q.tctrl    <= SFR_RST;
      end else begin
         q <= d;
      end
   end

   assign SFR_RDATA_O       = q.rdata;
   assign IRQ_CALL_O        = q.call;
   assign TIMER_TWO_PULSE_O = q.pulse;
   assign BAUD_RX_TICK_O    = t2_baud & t2_cfg.rx_src;
   assign BAUD_TX_TICK_O    = t2_baud & t2_cfg.tx_src;

   // checks on the call and the flags
   property p_global_mask;
      @(posedge CLOCK_I) disable iff (!RST_N_I)
      (INSTR_END_I && !q.irq_en[B_GLOBAL]) |=> (!IRQ_CALL_O.take ||
                                                IRQ_CALL_O.src == 4'(SRC_PF));
   endproperty
   a_global_mask: assert property (p_global_mask) else $error("masked source called");

   property p_pf_enable;
      @(posedge CLOCK_I) disable iff (!RST_N_I)
      (IRQ_CALL_O.take && IRQ_CALL_O.src == 4'(SRC_PF)) |-> $past(q.xctrl[B_PF_EN]);
   endproperty
   a_pf_enable: assert property (p_pf_enable) else $error("power loss not enabled");

   property p_after_return;
      @(posedge CLOCK_I) disable iff (!RST_N_I)
      (INSTR_END_I && RETURN_FROM_ISR_INSTR_I) |=> !IRQ_CALL_O.take;
   endproperty
   a_after_return: assert property (p_after_return) else $error("call right after return");

   property p_ctl_write;
      @(posedge CLOCK_I) disable iff (!RST_N_I)
      (INSTR_END_I && ctl_now) |=> !IRQ_CALL_O.take;
   endproperty
   a_ctl_write: assert property (p_ctl_write) else $error("call after control write");

   property p_vector;
      @(posedge CLOCK_I) disable iff (!RST_N_I)
      IRQ_CALL_O.take |-> (IRQ_CALL_O.vector == vector_of(IRQ_CALL_O.src));
   endproperty
   a_vector: assert property (p_vector) else $error("wrong vector");

   property p_high_yields;
      @(posedge CLOCK_I) disable iff (!RST_N_I)
      (q.active[1] && take) |-> (pick == 4'(SRC_PF));
   endproperty
   a_high_yields: assert property (p_high_yields) else $error("high routine preempted");

   property p_tie_break;
      @(posedge CLOCK_I) disable iff (!RST_N_I)
      (take && pick != 4'(SRC_PF) && hi[pick]) |-> (pick == hi_idx);
   endproperty
   a_tie_break: assert property (p_tie_break) else $error("natural order broken");

   property p_tf2_set;
      @(posedge CLOCK_I) disable iff (!RST_N_I)
      (t2_ovf && !baud_mode) |=> (q.t2ctrl[B_TF2] && TIMER_TWO_PULSE_O) ##1 !TIMER_TWO_PULSE_O;
   endproperty
   a_tf2_set: assert property (p_tf2_set) else $error("overflow flag or pulse");

   property p_baud_no_flag;
      @(posedge CLOCK_I) disable iff (!RST_N_I)
      (t2_ovf && baud_mode && !SFR_REQ_I.wr && !q.t2ctrl[B_TF2]) |=> !q.t2ctrl[B_TF2];
   endproperty
   a_baud_no_flag: assert property (p_baud_no_flag) else $error("baud set flag");

   property p_sample_rate;
      @(posedge CLOCK_I) disable iff (!RST_N_I)
      tick |=> !tick [*3] ##1 tick;
   endproperty
   a_sample_rate: assert property (p_sample_rate) else $error("sampling not every 4 clocks");
endmodule : ext_irq_unit

//--- verif/core_model.sv
// Purpose: core sequencer stand-in.
// Assumes: every instruction takes one cycle of four clocks.
// Notes:   no long call is modelled; the strobe keeps its pace.
module core_model (
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   output logic      instr_end_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [1:0] phase_q;
   // free running phase, so a request waits for the next boundary
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) phase_q <= 2'h0;
      else phase_q <= phase_q + 2'h1;
   end
   assign instr_end_o = (phase_q == 2'h3);
endmodule : core_model

//--- verif/tb_ext_irq_unit.sv
// Purpose: register-level tests of the interrupt unit, pointers, timer two.
// Assumes: one return from interrupt, from the power-loss routine; other routines stay in service.
// Notes:   serial and timer zero/one flags are held quiet.
module tb_ext_irq_unit;
   import ext_irq_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 0, rst_n = 0, we = 0, return_from_isr_instr = 0, ie;
   logic [15:0] wd = '0, dp;
   logic [6:0] pins = 7'h2b; // every pin idle
   logic [7:0] rdata;
   logic pulse, rx, tx;
   sfr_req_t req = '0;
   irq_call_t call;
   int err_count = 0, checks_done = 0;
   always #12.5 clk = ~clk;
   core_model core_model_inst (.clk_i(clk), .rst_n_i(rst_n), .instr_end_o(ie));
   ext_irq_unit ext_irq_unit_inst (.CLOCK_I(clk), .RST_N_I(rst_n), .SFR_REQ_I(req),
      .SFR_RDATA_O(rdata), .INSTR_END_I(ie), .RETURN_FROM_ISR_INSTR_I(return_from_isr_instr), .SER_IRQ_I(1'b0),
      .TF0_SET_I(1'b0), .TF1_SET_I(1'b0), .EXT_IRQ_ZERO_LOW_N_I(pins[0]),
      .EXT_IRQ_ONE_LOW_N_I(pins[1]), .EXT_IRQ_TWO_HIGH_I(pins[2]),
      .EXT_IRQ_THREE_LOW_N_I(pins[3]), .EXT_IRQ_FOUR_HIGH_I(pins[4]),
      .EXT_IRQ_FIVE_LOW_N_I(pins[5]), .POWER_LOSS_I(pins[6]), .DATA_POINTER_WE_I(we),
      .DATA_POINTER_WDATA_I(wd), .DATA_POINTER_O(dp), .IRQ_CALL_O(call),
      .TIMER_TWO_PULSE_O(pulse), .BAUD_RX_TICK_O(rx), .BAUD_TX_TICK_O(tx));
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
      checks_done++;
      if (s !== e) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   // one-cycle strobes, released at the edge that takes them
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk) req <= '{a, 1'b1, 1'b0, v};
      @(posedge clk) req <= '0;
   endtask : wr
   task automatic rd(input string n, input logic [7:0] a, input logic [7:0] e);
      @(posedge clk) req <= '{a, 1'b0, 1'b1, 8'h00};
      @(posedge clk) req <= '0;
      #1 chk(n, {8'h00, e}, {8'h00, rdata});
   endtask : rd
   // bounded wait for a one-clock pulse: 0 call, 1 timer pulse, 2 tx tick
   task automatic wt(input int k, input string n);
      for (int i = 0; i < 300; i++) begin
         @(posedge clk) #1;
         if ((k == 0 ? call.take : k == 1 ? pulse : tx) === 1'b1) return;
      end
      chk(n, 16'h0001, 16'h0000);
   endtask : wt
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : tally_and_finish
   initial begin
      #200us err_count++;
      tally_and_finish;
   end
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1;
      rd("rate", 8'h8e, 8'h01);
      rd("sel", 8'h86, 8'h00);
      $display("test reset done");
      wr(8'h82, 8'h34); wr(8'h83, 8'h12); wr(8'h84, 8'h78); wr(8'h85, 8'h56);
      rd("dp1hi", 8'h85, 8'h56);
      chk("dp0", 16'h1234, dp);
      wr(8'h86, 8'h01);
      rd("sel1", 8'h86, 8'h01);
      chk("dp1", 16'h5678, dp);
      @(posedge clk) begin we <= 1; wd <= 16'habcd; end
      @(posedge clk) we <= 0;
      #1 chk("dpw", 16'habcd, dp);
      $display("test pointers done");
      wr(8'ha8, 8'h81);
      pins[0] <= 1'b0; // level mode, held until taken
      wt(0, "take0");
      chk("src0", 16'h0000, {12'h000, call.src});
      chk("vec0", 16'h0003, call.vector);
      @(posedge clk);
      pins[0] <= 1'b1;
      wr(8'ha8, 8'h00); wr(8'hd8, 8'h20);
      repeat (8) @(posedge clk);
      pins[6] <= 1'b1; // rising edge, held high well past four clocks
      wt(0, "takepf");
      chk("srcpf", 16'h000a, {12'h000, call.src});
      chk("vecpf", 16'h0053, call.vector);
      @(posedge clk);
      pins[6] <= 1'b0; // low for many clocks after the high phase
      // return from the power-loss routine; its flag is still pending, so it comes back
      return_from_isr_instr <= 1'b1;
      do @(posedge clk); while (!ie);
      return_from_isr_instr <= 1'b0;
      wt(0, "retake");
      chk("srcpf2", 16'h000a, {12'h000, call.src});
      $display("test interrupts done");
      wr(8'hca, 8'hfe); wr(8'hcb, 8'hff); wr(8'hcc, 8'hfe); wr(8'hcd, 8'hff);
      wr(8'h8e, 8'h21); wr(8'hc8, 8'h04);
      wt(1, "t2pulse");
      rd("tf2", 8'hc8, 8'h84);
      wr(8'hc8, 8'h00); // stop first: an overflow in the clearing cycle would win
      wr(8'hc8, 8'h14);
      wt(2, "txtick");
      chk("rxquiet", 16'h0000, {15'h0000, rx});
      rd("notf2", 8'hc8, 8'h14);
      $display("test timer two done");
      tally_and_finish;
   end
endmodule : tb_ext_irq_unit
